// *** verilog/event_timer.sv ***
// one timer channel: free-run event, two-phase and one-shot modes behind a wishbone slave
// ==========================================================
`timescale 1ns/100ps
`default_nettype none

module event_timer #(
  parameter int CHANNEL_ID = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins
  input wire logic timer_in_pin_i,
  input wire logic timer_out_pin_i,
  input wire logic subclk_i,
  output logic timer_out_pin_o,
  output logic timer_out_oe_o,
  // neighbouring channels, one-cycle pulses on clk_i
  input wire logic preceding_channel_i,
  input wire logic following_channel_i,
  output logic ovf_o,
  // interrupt
  output logic irq_o
);

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  logic [2:0] pin_raw;
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] lvl_reg;
  logic [2:0] agree;
  logic [2:0] rise;
  logic [2:0] fall;

  assign pin_raw = {subclk_i, timer_out_pin_i, timer_in_pin_i};
  assign agree = ~(s2_reg ^ s3_reg);
  assign rise = agree & s3_reg & ~lvl_reg;
  assign fall = agree & ~s3_reg & lvl_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      lvl_reg <= 3'h0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (lvl_reg & ~agree) | (s3_reg & agree);
    end
  end

  // ==========================================================
  // count-source enables
  logic [3:0] tick_vec;

  clock_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sub_edge_i(rise[2]),
    .tick_o(tick_vec)
  );

  // ==========================================================
  // wishbone decode: ack one cycle after the request, write on the ack edge
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction : byte_mask

  timer_pkg::ctrl_t ctrl_reg;
  timer_pkg::ctrl_t ctrl_new;
  logic [15:0] cnt_reg;
  logic [15:0] reload_reg;
  logic [2:0] status_reg;
  logic [2:0] enable_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_data;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] ctrl_merge;
  logic [31:0] cnt_merge;
  logic [31:0] reload_merge;
  logic req;
  logic wr_fire;
  logic ctrl_wr;
  logic cnt_wr;
  logic soft_trig;
  logic [2:0] clr;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wmask = byte_mask(wb_sel_i);
  assign wval = wb_dat_i & wmask;
  assign ctrl_merge = (32'(ctrl_reg) & ~wmask) | wval;
  assign cnt_merge = (32'(cnt_reg) & ~wmask) | wval;
  assign reload_merge = (32'(reload_reg) & ~wmask) | wval;
  assign ctrl_new = timer_pkg::ctrl_t'(ctrl_merge[timer_pkg::CTRL_W-1:0]);
  assign ctrl_wr = wr_fire && (wb_adr_i == timer_pkg::CTRL_OFS);
  assign cnt_wr = wr_fire && (wb_adr_i == timer_pkg::COUNT_OFS);
  assign soft_trig = wr_fire && (wb_adr_i == timer_pkg::ONESHOT_OFS) && wval[0];
  assign clr = (wr_fire && (wb_adr_i == timer_pkg::CLEAR_OFS)) ? wval[timer_pkg::IRQ_W-1:0] : 3'h0;

  always_comb begin
    case (wb_adr_i)
      timer_pkg::CTRL_OFS: rd_data = 32'(ctrl_reg);
      timer_pkg::COUNT_OFS: rd_data = 32'(cnt_reg);
      timer_pkg::RELOAD_OFS: rd_data = 32'(reload_reg);
      timer_pkg::STATUS_OFS: rd_data = 32'(status_reg);
      timer_pkg::ENABLE_OFS: rd_data = 32'(enable_reg);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdata_reg <= rd_data;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================
  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
      reload_reg <= timer_pkg::RELOAD_RESET;
      enable_reg <= timer_pkg::IRQ_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ctrl_new;
      end
      if (wr_fire && (wb_adr_i == timer_pkg::RELOAD_OFS)) begin
        reload_reg <= reload_merge[timer_pkg::CNT_W-1:0];
      end
      if (wr_fire && (wb_adr_i == timer_pkg::ENABLE_OFS)) begin
        enable_reg <= (enable_reg & ~wmask[2:0]) | wval[2:0];
      end
    end
  end

  // ==========================================================
  // event sources and quadrature decode
  logic quad_ok;
  logic use_x4;
  logic free_src;
  logic a_lvl;
  logic b_lvl;
  logic q_up;
  logic q_dn;
  logic free_on;
  logic quad_on;
  logic cnt_up;
  logic cnt_dn;

  assign quad_ok = (CHANNEL_ID >= timer_pkg::CHAN_NORMAL_ONLY) && (CHANNEL_ID <= timer_pkg::CHAN_X4_ONLY);
  assign use_x4 = (CHANNEL_ID == timer_pkg::CHAN_X4_ONLY) ||
                  ((CHANNEL_ID == timer_pkg::CHAN_SELECTABLE) && ctrl_reg.x4);
  assign free_src = ctrl_reg.event_preceding ? preceding_channel_i : fall[0];
  assign a_lvl = lvl_reg[0];
  assign b_lvl = lvl_reg[1];

  always_comb begin
    if (use_x4) begin
      q_up = (rise[0] && b_lvl) || (fall[0] && !b_lvl) || (rise[1] && !a_lvl) || (fall[1] && a_lvl);
      q_dn = (fall[0] && b_lvl) || (rise[0] && !b_lvl) || (rise[1] && a_lvl) || (fall[1] && !a_lvl);
    end else begin
      q_up = rise[0] && b_lvl;
      q_dn = fall[0] && b_lvl;
    end
  end

  // the up/down flag is sampled at each edge, so a change applies to the next one
  assign free_on = ctrl_reg.start && (ctrl_reg.mode == timer_pkg::MODE_FREERUN);
  assign quad_on = ctrl_reg.start && (ctrl_reg.mode == timer_pkg::MODE_TWOPHASE) && quad_ok;
  assign cnt_up = (free_on && free_src && ctrl_reg.up) || (quad_on && q_up);
  assign cnt_dn = (free_on && free_src && !ctrl_reg.up) || (quad_on && q_dn);

  // ==========================================================
  // one-shot control
  timer_pkg::os_state_t os_state_reg;
  logic retrig_reg;
  logic out_reg;
  logic os_trig;
  logic os_mode;
  logic os_go;
  logic os_tick;
  logic os_end;
  logic os_stop;

  assign os_mode = (ctrl_reg.mode == timer_pkg::MODE_ONESHOT);
  assign os_tick = tick_vec[ctrl_reg.clk_sel];

  always_comb begin
    case (ctrl_reg.trig)
      timer_pkg::TRIG_SOFT: os_trig = soft_trig;
      timer_pkg::TRIG_PIN_FALL: os_trig = fall[0];
      timer_pkg::TRIG_PIN_RISE: os_trig = rise[0];
      timer_pkg::TRIG_NEIGHBOUR: os_trig = ctrl_reg.neighbour_next ? following_channel_i : preceding_channel_i;
      default: os_trig = 1'b0;
    endcase
  end

  assign os_go = os_mode && ctrl_reg.start && os_trig;
  assign os_stop = ctrl_wr && os_mode && ctrl_reg.start && !ctrl_new.start;
  assign os_end = (os_state_reg == timer_pkg::OS_RUN) && os_tick && !retrig_reg && (cnt_reg <= timer_pkg::CNT_ONE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      os_state_reg <= timer_pkg::OS_IDLE;
      out_reg <= 1'b0;
      retrig_reg <= 1'b0;
    end else if (os_stop || !os_mode) begin
      os_state_reg <= timer_pkg::OS_IDLE;
      out_reg <= 1'b0;
      retrig_reg <= 1'b0;
    end else begin
      case (os_state_reg)
        timer_pkg::OS_IDLE: begin
          retrig_reg <= 1'b0;
          if (os_go) begin
            os_state_reg <= timer_pkg::OS_RUN;
            out_reg <= 1'b1;
          end
        end
        timer_pkg::OS_RUN: begin
          // a fresh trigger beats the tick that consumes the old one
          retrig_reg <= os_go || (retrig_reg && !os_tick);
          if (os_end) begin
            os_state_reg <= timer_pkg::OS_IDLE;
            out_reg <= 1'b0;
            retrig_reg <= 1'b0;
          end
        end
        default: begin
          os_state_reg <= timer_pkg::OS_IDLE;
          out_reg <= 1'b0;
          retrig_reg <= 1'b0;
        end
      endcase
    end
  end

  assign timer_out_pin_o = out_reg;
  assign timer_out_oe_o = os_mode;

  // ==========================================================
  // the counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= timer_pkg::COUNT_RESET;
    end else if (cnt_wr) begin
      cnt_reg <= cnt_merge[timer_pkg::CNT_W-1:0];
    end else if (os_stop) begin
      cnt_reg <= reload_reg;
    end else if (os_mode) begin
      if ((os_state_reg == timer_pkg::OS_IDLE) && os_go) begin
        cnt_reg <= reload_reg;
      end else if ((os_state_reg == timer_pkg::OS_RUN) && os_tick) begin
        if (retrig_reg || os_end) begin
          cnt_reg <= reload_reg;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end else if (cnt_up) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (cnt_dn) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // ==========================================================
  // interrupt status: set wins over a clear in the same cycle
  logic unf_ev;
  logic ovf_ev;
  logic [2:0] events;
  logic ovf_reg;

  assign unf_ev = cnt_dn && !cnt_wr && (cnt_reg == timer_pkg::CNT_ZERO);
  assign ovf_ev = cnt_up && !cnt_wr && (cnt_reg == timer_pkg::CNT_MAX);
  assign events = {os_end || os_stop, ovf_ev, unf_ev};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= timer_pkg::IRQ_RESET;
      ovf_reg <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clr) | events;
      ovf_reg <= unf_ev || ovf_ev;
    end
  end

  assign ovf_o = ovf_reg;
  assign irq_o = |(status_reg & enable_reg);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_fire;
    (os_state_reg == timer_pkg::OS_IDLE) && os_go && !os_stop && !cnt_wr;
  endsequence

  chk_free_up_step: assert property ((cnt_up && !cnt_wr && cnt_reg != timer_pkg::CNT_MAX)
    |=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("count up step wrong");
  chk_wrap_overflow: assert property (ovf_ev
    |=> cnt_reg == timer_pkg::CNT_ZERO && status_reg[timer_pkg::STATUS_OVF]) else $error("overflow wrap wrong");
  chk_unf_no_reload: assert property (unf_ev
    |=> cnt_reg == timer_pkg::CNT_MAX && status_reg[timer_pkg::STATUS_UNF]) else $error("underflow wrap wrong");
  chk_dir_flag: assert property ((free_on && free_src && !ctrl_reg.up) |-> cnt_dn && !cnt_up)
    else $error("direction flag ignored");
  chk_quad_normal: assert property ((quad_on && !use_x4 && rise[0] && b_lvl) |-> cnt_up)
    else $error("normal quadrature up missed");
  chk_quad_x4_down: assert property ((quad_on && use_x4 && rise[1] && a_lvl && !rise[0] && !fall[0])
    |-> cnt_dn && !cnt_up) else $error("x4 down missed");
  chk_oneshot_fire: assert property (s_fire |=> timer_out_pin_o && cnt_reg == $past(reload_reg))
    else $error("one-shot start wrong");
  chk_oneshot_end: assert property ((os_end && !os_stop && !cnt_wr)
    |=> !timer_out_pin_o && status_reg[timer_pkg::STATUS_DONE] && os_state_reg == timer_pkg::OS_IDLE)
    else $error("one-shot end wrong");
  chk_stop_reload: assert property (os_stop
    |=> !timer_out_pin_o && cnt_reg == $past(reload_reg) && status_reg[timer_pkg::STATUS_DONE])
    else $error("stop did not reload");
  chk_out_quiet: assert property (!os_mode |=> !timer_out_pin_o) else $error("pulse outside one-shot");
  chk_wb_ack: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");

endmodule : event_timer
`default_nettype wire

// *** verilog/timer_pkg.sv ***
// shared constants and types of the event and one-shot timer channel
package timer_pkg;

  // ==========================================================
  // register map (byte offsets)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ONESHOT_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] RELOAD_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CLEAR_OFS = 8'h14;
  localparam logic [7:0] ENABLE_OFS = 8'h18;

  // ==========================================================
  // counter values and reset values
  localparam int CNT_W = 16;
  localparam int CTRL_W = 11;
  localparam int IRQ_W = 3;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // status bit positions
  localparam int STATUS_UNF = 0;
  localparam int STATUS_OVF = 1;
  localparam int STATUS_DONE = 2;

  // channels with quadrature inputs
  localparam int CHAN_NORMAL_ONLY = 2;
  localparam int CHAN_SELECTABLE = 3;
  localparam int CHAN_X4_ONLY = 4;

  // ==========================================================
  // prescaler counts
  localparam int PRE_W = 5;
  localparam logic [4:0] PRE_LAST = 5'h1f;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // ==========================================================
  // modes and selectors
  typedef enum logic [1:0] {MODE_FREERUN = 2'h0, MODE_TWOPHASE = 2'h1, MODE_ONESHOT = 2'h2} mode_t;
  typedef enum logic [1:0] {TRIG_SOFT = 2'h0, TRIG_PIN_FALL = 2'h1, TRIG_PIN_RISE = 2'h2,
                            TRIG_NEIGHBOUR = 2'h3} trig_t;
  typedef enum logic [1:0] {CLK_DIV1 = 2'h0, CLK_DIV8 = 2'h1, CLK_DIV32 = 2'h2, CLK_SUB32 = 2'h3} clksel_t;
  typedef enum logic [1:0] {OS_IDLE = 2'b01, OS_RUN = 2'b10} os_state_t;

  // control register, bit 0 is the count start flag
  typedef struct packed {
    clksel_t clk_sel;
    logic neighbour_next;
    trig_t trig;
    logic x4;
    logic event_preceding;
    mode_t mode;
    logic up;
    logic start;
  } ctrl_t;

endpackage : timer_pkg

// *** verilog/clock_prescaler.sv ***
// count-source enables: undivided, divided by 8 and 32, subclock divided by 32
`timescale 1ns/100ps
`default_nettype none

module clock_prescaler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // synchronised subclock rising edge
  input wire logic sub_edge_i,
  // one-cycle enables, indexed by clock select
  output logic [3:0] tick_o
);

  logic [timer_pkg::PRE_W-1:0] main_reg;
  logic [timer_pkg::PRE_W-1:0] sub_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_reg <= '0;
    end else begin
      main_reg <= main_reg + 1'b1;
    end
  end

  // the subclock is far slower than clk_i, so one edge is one tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_reg <= '0;
    end else if (sub_edge_i) begin
      sub_reg <= sub_reg + 1'b1;
    end
  end

  always_comb begin
    tick_o[timer_pkg::CLK_DIV1] = 1'b1;
    tick_o[timer_pkg::CLK_DIV8] = (main_reg[2:0] == timer_pkg::DIV8_LAST);
    tick_o[timer_pkg::CLK_DIV32] = (main_reg == timer_pkg::PRE_LAST);
    tick_o[timer_pkg::CLK_SUB32] = sub_edge_i && (sub_reg == timer_pkg::PRE_LAST);
  end

endmodule : clock_prescaler
`default_nettype wire

// *** verif/pulse_source.sv ***
// far-side model: input pin source, quadrature encoder, neighbour channel wraps and subclock
`timescale 1ns/100ps
`default_nettype none

module pulse_source (
  // clock
  input wire logic clk_i,
  // out pin as driven by the timer
  input wire logic out_oe_i,
  input wire logic out_pin_i,
  // pins toward the timer
  output logic in_pin_o,
  output logic out_pin_o,
  output logic subclk_o,
  // neighbouring channel wraps, one cycle each
  output logic prev_ovf_o,
  output logic next_ovf_o
);
  logic enc_b = 1'b0;
  logic [1:0] sub_cnt = 2'h0;

  // ==========================================================
  // pins
  initial begin
    in_pin_o = 1'b1;
    prev_ovf_o = 1'b0;
    next_ovf_o = 1'b0;
    subclk_o = 1'b0;
  end

  // the encoder line is also the timer's output pin in one-shot mode; while it drives, the wire carries its level
  assign out_pin_o = out_oe_i ? out_pin_i : enc_b;

  // slow subclock, eight system cycles a period
  always @(posedge clk_i) begin
    sub_cnt <= sub_cnt + 2'h1;
    if (sub_cnt == 2'h3) subclk_o <= ~subclk_o;
  end

  // ==========================================================
  // stimulus tasks
  // each change is held past the three-flop synchroniser and the count update
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk_i);
    in_pin_o <= a;
    enc_b <= b;
    repeat (8) @(posedge clk_i);
  endtask : set_pins

  task automatic pulse(input logic nxt);
    @(posedge clk_i);
    if (nxt) next_ovf_o <= 1'b1;
    else prev_ovf_o <= 1'b1;
    @(posedge clk_i);
    prev_ovf_o <= 1'b0;
    next_ovf_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : pulse
endmodule : pulse_source
`default_nettype wire

// *** verif/event_timer_tb.sv ***
// self-checking bench of one timer channel: free-run, two-phase and one-shot counting
`timescale 1ns/100ps
`default_nettype none

module event_timer_tb;
  // ==========================================================
  // signals
  logic clk_i, ack, pin_in, pin_out, sub, prev, nxt, out_o, oe, ovf, irq;
  logic rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  int err_count = 0, checked = 0, run = 0, last_w = 0, pulses = 0, ovf_seen = 0;

  event_timer #(.CHANNEL_ID(3)) i_event_timer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .timer_in_pin_i(pin_in),
    .timer_out_pin_i(pin_out), .subclk_i(sub), .timer_out_pin_o(out_o), .timer_out_oe_o(oe),
    .preceding_channel_i(prev), .following_channel_i(nxt), .ovf_o(ovf), .irq_o(irq)
  );

  pulse_source i_pulse_source (
    .clk_i(clk_i), .out_oe_i(oe), .out_pin_i(out_o), .in_pin_o(pin_in), .out_pin_o(pin_out),
    .subclk_o(sub), .prev_ovf_o(prev), .next_ovf_o(nxt)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // width of the last one-shot pulse, in clock cycles
  always @(posedge clk_i) begin
    if (out_o === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_w <= run;
      pulses <= pulses + 1;
      run <= 0;
    end
  end

  // wraps reported toward the neighbouring channels, one pulse each
  always @(posedge clk_i) begin
    if (ovf === 1'b1) ovf_seen <= ovf_seen + 1;
  end

  // ==========================================================
  // bus and compare helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ack is read at the rising edge, before that edge's updates land
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      err_count++;
      $display("ERROR wb_ack expected 1 seen %b", ack);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // let the write settle so outputs are compared after it has landed
    @(negedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, {16'h0, e}, {16'h0, q[15:0]});
  endtask : rchk

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic up, input logic x4, input logic pre,
                                      input logic [1:0] t, input logic nb, input logic [1:0] cs, input logic go);
    timer_pkg::ctrl_t c;
    c = {cs, nb, t, x4, pre, m, up, go};
    return {21'h0, c};
  endfunction : ctl

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rchk("ctrl_reset", timer_pkg::CTRL_OFS, 16'h0);
    rchk("reload_reset", timer_pkg::RELOAD_OFS, 16'h0);
    wr(timer_pkg::STATUS_OFS, 32'h7);
    wr(8'h1c, 32'hffff);
    rchk("status_read_only", timer_pkg::STATUS_OFS, 16'h0);
    rchk("unmapped_read", 8'h1c, 16'h0);
  endtask : t_regs

  task automatic t_freerun;
    wr(timer_pkg::ENABLE_OFS, 32'h7);
    wr(timer_pkg::CTRL_OFS, ctl(2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
    i_pulse_source.set_pins(1'b0, 1'b0);
    rchk("down_wrap", timer_pkg::COUNT_OFS, 16'hffff);
    rchk("unf_status", timer_pkg::STATUS_OFS, 16'h1);
    chk("irq_raised", 32'h1, {31'h0, irq});
    chk("no_pulse", 32'h0, {30'h0, oe, out_o});
    i_pulse_source.set_pins(1'b1, 1'b0);
    rchk("rise_ignored", timer_pkg::COUNT_OFS, 16'hffff);
    wr(timer_pkg::CTRL_OFS, ctl(2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
    i_pulse_source.set_pins(1'b0, 1'b0);
    rchk("up_wrap", timer_pkg::COUNT_OFS, 16'h0);
    rchk("ovf_status", timer_pkg::STATUS_OFS, 16'h3);
    wr(timer_pkg::ENABLE_OFS, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(timer_pkg::CLEAR_OFS, 32'h3);
    wr(timer_pkg::ENABLE_OFS, 32'h7);
    rchk("status_cleared", timer_pkg::STATUS_OFS, 16'h0);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wr(timer_pkg::CTRL_OFS, ctl(2'h0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 2'h0, 1'b1));
    i_pulse_source.set_pins(1'b1, 1'b0);
    i_pulse_source.set_pins(1'b0, 1'b0);
    i_pulse_source.pulse(1'b0);
    i_pulse_source.pulse(1'b1);
    i_pulse_source.pulse(1'b0);
    rchk("preceding_count", timer_pkg::COUNT_OFS, 16'h2);
    chk("ovf_pulses", 32'h2, 32'(ovf_seen));
  endtask : t_freerun

  task automatic t_quad;
    bit a[14] = '{1, 0, 0, 1, 0, 0, 1, 1, 0, 0, 0, 1, 1, 0};
    bit b[14] = '{1, 1, 0, 0, 0, 1, 1, 0, 0, 1, 0, 0, 1, 1};
    int d[14] = '{1, -1, 0, 0, 0, 0, 1, 1, 1, 1, -1, -1, -1, -1};
    logic [15:0] e = 16'hffff;
    wr(timer_pkg::CTRL_OFS, 32'h0);
    i_pulse_source.set_pins(1'b0, 1'b1);
    wr(timer_pkg::COUNT_OFS, 32'hffff);
    wr(timer_pkg::CLEAR_OFS, 32'h7);
    wr(timer_pkg::CTRL_OFS, ctl(2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
    for (int i = 0; i < 14; i++) begin
      if (i == 6) wr(timer_pkg::CTRL_OFS, ctl(2'h1, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
      i_pulse_source.set_pins(a[i], b[i]);
      e = e + 16'(d[i]);
      rchk("quad_count", timer_pkg::COUNT_OFS, e);
    end
    rchk("quad_wrap_status", timer_pkg::STATUS_OFS, 16'h3);
  endtask : t_quad

  // act: 0 soft, 1 pin fall, 2 pin rise, 3 preceding, 4 following, 5 soft twice
  task automatic os_run(input logic [31:0] c, input int act, input logic [15:0] r, input int lo, input int hi);
    int p0 = pulses;
    int n = 0;
    wr(timer_pkg::CLEAR_OFS, 32'h7);
    wr(timer_pkg::RELOAD_OFS, {16'h0, r});
    wr(timer_pkg::CTRL_OFS, c);
    p0 = pulses;
    if (act == 0 || act == 5) wr(timer_pkg::ONESHOT_OFS, 32'h1);
    if (act == 5) wr(timer_pkg::ONESHOT_OFS, 32'h1);
    if (act == 1 || act == 2) i_pulse_source.set_pins(act == 2, 1'b0);
    if (act == 3 || act == 4) i_pulse_source.pulse(act == 4);
    while (pulses == p0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    checked++;
    if (last_w < lo || last_w > hi || pulses == p0) begin
      err_count++;
      $display("ERROR pulse width expected %0d to %0d seen %0d", lo, hi, last_w);
    end
    rchk("os_reloaded", timer_pkg::COUNT_OFS, r);
    rchk("os_done", timer_pkg::STATUS_OFS, 16'h4);
  endtask : os_run

  task automatic t_oneshot;
    int lo[4] = '{3, 16, 64, 500};
    int hi[4] = '{4, 26, 98, 800};
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1), 0, 16'h3, 3, 4);
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 2'h0, 1'b1), 2, 16'h3, 3, 4);
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 2'h0, 1'b1), 1, 16'h3, 3, 4);
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h3, 1'b0, 2'h0, 1'b1), 3, 16'h3, 3, 4);
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 2'h0, 1'b1), 4, 16'h3, 3, 4);
    os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1), 5, 16'h20, 34, 38);
    for (int k = 0; k < 4; k++) begin
      os_run(ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'(k), 1'b1), 0, 16'h3, lo[k], hi[k]);
    end
    chk("os_irq", 32'h1, {31'h0, irq});
    wr(timer_pkg::CLEAR_OFS, 32'h7);
    wr(timer_pkg::RELOAD_OFS, 32'h40);
    wr(timer_pkg::CTRL_OFS, ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1));
    wr(timer_pkg::ONESHOT_OFS, 32'h1);
    @(negedge clk_i);
    chk("os_high", 32'h3, {30'h0, oe, out_o});
    wr(timer_pkg::CTRL_OFS, ctl(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0));
    @(negedge clk_i);
    chk("abort_low", 32'h0, {31'h0, out_o});
    rchk("abort_reload", timer_pkg::COUNT_OFS, 16'h40);
    rchk("abort_status", timer_pkg::STATUS_OFS, 16'h4);
  endtask : t_oneshot

  // ==========================================================
  // run control
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_freerun;
    t_quad;
    t_oneshot;
    close_out;
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    $display("ERROR watchdog expected end seen hang");
    close_out;
  end
endmodule : event_timer_tb
`default_nettype wire
